// ### rtl/inbound_window_pkg.sv
// Constants for the inbound VMEbus window decoder
// Function
// [RL1] User modifier fields four bits, codes 0x10-0x1F
// [RL2] User modifier fields reset to zero
// [RL3] Claim only when enabled and master enabled
// [RL4] Match when base <= address < bound
// [RL5] Window 0 fields use bits 31:12
// [RL6] Window 1 base uses bits 31:16
// [RL7] Program/data filter 01/10/11, resets 11
// [RL8] Privilege filter 01/10/11, resets 11
// [RL9] Window 0 space codes A16/A24/A32/user1/user2
// [RL10] Window 1 space code 000 reserved
// [RL11] Local space memory/IO/config, resets 00
// [RL12] Posted write, prefetch enables reset 0
// [RL13] Posting and prefetch only for memory space
// [RL14] Wide enable resets 0 window0, 1 window1
// [RL15] Lock enable resets 0 window0, 1 window1
// [RL16] Local address adds offset above granularity
// [RL17] Control bit placement as assigned
// [RL18] All fields reset on power-up and bus reset; the status miss count clears on power-up only
`default_nettype none
package inbound_window_pkg;
    localparam logic [11:0] OFS_W0_CTL  = 12'h0f00;
    localparam logic [11:0] OFS_W0_BASE = 12'h0f04;
    localparam logic [11:0] OFS_W0_BND  = 12'h0f08;
    localparam logic [11:0] OFS_W0_OFS  = 12'h0f0c;
    localparam logic [11:0] OFS_W1_CTL  = 12'h0f14;
    localparam logic [11:0] OFS_W1_BASE = 12'h0f18;
    localparam logic [11:0] OFS_W1_BND  = 12'h0f1c;
    localparam logic [11:0] OFS_W1_OFS  = 12'h0f20;
    localparam logic [11:0] OFS_USER_CODES = 12'h040c;
    localparam logic [11:0] OFS_STATUS  = 12'h0f80;
    // Control field positions
    localparam int CTL_EN    = 31;
    localparam int CTL_POST    = 30;
    localparam int CTL_PREF    = 29;
    localparam int CTL_PROG_L  = 22;
    localparam int CTL_SUP_L   = 20;
    localparam int CTL_SPACE_L = 16;
    localparam int CTL_WIDE    = 7;
    localparam int CTL_LOCK    = 6;
    localparam int CTL_LOCAL_L = 0;
    // Writable masks and reset values
    localparam logic [31:0] CTL_MASK   = 32'he0f7_00c3;
    localparam logic [31:0] CTL0_RESET = 32'h00f0_0000;
    localparam logic [31:0] CTL1_RESET = 32'h00f0_00c0;
    localparam logic [31:0] W0_ADDR_MASK = 32'hffff_f000;
    localparam logic [31:0] W1_ADDR_MASK = 32'hffff_0000;
    localparam int W0_GRAN = 12;
    localparam int W1_GRAN = 16;
    localparam int UAM1_L = 24;
    localparam int UAM2_L = 16;
    localparam logic [31:0] UAM_MASK  = 32'h0f0f_0000;
    localparam logic [31:0] UAM_FIXED = 32'h4040_0000;
    localparam logic [1:0] FILT_BOTH = 2'h3;
    // Space codes
    localparam logic [2:0] SPC_A16   = 3'h0;
    localparam logic [2:0] SPC_A24   = 3'h1;
    localparam logic [2:0] SPC_A32   = 3'h2;
    localparam logic [2:0] SPC_USER1 = 3'h6;
    localparam logic [2:0] SPC_USER2 = 3'h7;
    localparam logic [1:0] LOC_MEM  = 2'h0;
    localparam logic [1:0] LOC_IO   = 2'h1;
    localparam logic [1:0] LOC_CFG  = 2'h2;
    // Upper two bits of every user modifier code
    localparam logic [1:0] USER_CODE_HI = 2'h1;
endpackage : inbound_window_pkg
`default_nettype wire

// ### rtl/window_match.sv
// One inbound window: modifier filter, range compare and translation
`default_nettype none
module window_match
    import inbound_window_pkg::*;
#(
    parameter int  GRAN      = 12,
    parameter bit  A16_OK    = 1'b1
)(
    // Window programming
    input  wire logic [31:0] ctl,
    input  wire logic [31:0] base,
    input  wire logic [31:0] bound,
    input  wire logic [31:0] offset,
    input  wire logic [3:0]  user1_am,
    input  wire logic [3:0]  user2_am,
    input  wire logic        master_en,
    // Incoming cycle
    input  wire logic [5:0]  am,
    input  wire logic [31:0] addr,
    // Result
    output logic             hit,
    output logic [31:0]      local_addr
);
    logic [31:0] hi_mask;
    logic [31:0] a_hi;
    logic        space_ok;
    logic        is_prog;
    logic        is_super;
    logic [1:0]  prog_filt;
    logic [1:0]  sup;
    logic [2:0]  space_sel;

    // Only the two mask widths below are served
    if (GRAN != 12 && GRAN != 16)
    begin : g_bad_gran
        $error("window_match: granularity must be 12 or 16");
    end

    // Upper-bit compare; low bits are ignored below the granularity
    assign hi_mask = ~((32'h0000_0001 << GRAN) - 32'h0000_0001); // [RL5] [RL6]
    assign a_hi    = addr & hi_mask;
    assign prog_filt = ctl[CTL_PROG_L +: 2];
    assign sup       = ctl[CTL_SUP_L +: 2];
    assign space_sel = ctl[CTL_SPACE_L +: 3];
    // Standard modifier: bit 2 set means supervisor, bits 1:0 == 2 program
    assign is_prog  = (am[1:0] == 2'h2);
    assign is_super = am[2];

    // Space check against the modifier; user codes are 0x10-0x1F
    always_comb
    begin
        space_ok = 1'b0;
        unique case (space_sel) // [RL9] [RL10]
            SPC_A16:   space_ok = A16_OK && (am[5:3] == 3'h5);
            SPC_A24:   space_ok = (am[5:3] == 3'h7);
            SPC_A32:   space_ok = (am[5:3] == 3'h1);
            SPC_USER1: space_ok = (am == {USER_CODE_HI, user1_am}); // [RL1]
            SPC_USER2: space_ok = (am == {USER_CODE_HI, user2_am}); // [RL1]
            default:   space_ok = 1'b0;
        endcase
    end

    // User codes bypass the program and privilege filters
    always_comb
    begin
        hit = ctl[CTL_EN] && master_en && space_ok // [RL3]
              && (a_hi >= (base & hi_mask)) && (a_hi < (bound & hi_mask)); // [RL4]
        if (space_sel != SPC_USER1 && space_sel != SPC_USER2)
        begin
            if (!(is_prog ? prog_filt[1] : prog_filt[0]))   // [RL7]
                hit = 1'b0;
            if (!(is_super ? sup[1] : sup[0]))  // [RL8]
                hit = 1'b0;
        end
    end

    // Translate upper bits, pass lower bits through
    assign local_addr = ((addr + (offset & hi_mask)) & hi_mask) | (addr & ~hi_mask); // [RL16]
endmodule : window_match
`default_nettype wire

// ### rtl/inbound_window_decode.sv
// Inbound VMEbus window decoder with AHB-Lite register slave
//
// Design decision made here: the AHB-Lite register port.
`default_nettype none
module inbound_window_decode
    import inbound_window_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // System reset and local master enable
    input  wire logic        vme_reset_n,
    input  wire logic        bus_master_enable,
    // Incoming VMEbus cycle
    input  wire logic        vme_cycle_valid,
    input  wire logic [5:0]  vme_am,
    input  wire logic [31:0] vme_addr,
    input  wire logic        vme_write,
    input  wire logic        vme_rmw,
    // Forwarded local request
    output logic             local_valid,
    output logic [31:0]      local_addr,
    output logic [1:0]       local_space,
    output logic             local_write,
    output logic             local_posted,
    output logic             local_prefetch,
    output logic             local_wide,
    output logic             local_lock,
    output logic             local_window
);
    import inbound_window_pkg::*;

    logic [31:0] ctl_reg [2];
    logic [31:0] base_reg [2];
    logic [31:0] bound_reg [2];
    logic [31:0] ofs_reg [2];
    logic [31:0] uam_reg;
    logic [11:0] wa_reg;
    logic        wr_pend_reg;
    logic [1:0]  hit;
    logic [31:0] xaddr [2];
    logic [1:0]  miss_cnt_reg;
    logic [31:0] rd_next;

    // Register bank address decode, shared by read and write
    function automatic logic [4:0] reg_sel(input logic [11:0] a);
        unique case (a)
            OFS_W0_CTL:  reg_sel = 5'h00;
            OFS_W0_BASE: reg_sel = 5'h01;
            OFS_W0_BND:  reg_sel = 5'h02;
            OFS_W0_OFS:  reg_sel = 5'h03;
            OFS_W1_CTL:  reg_sel = 5'h04;
            OFS_W1_BASE: reg_sel = 5'h05;
            OFS_W1_BND:  reg_sel = 5'h06;
            OFS_W1_OFS:  reg_sel = 5'h07;
            OFS_USER_CODES: reg_sel = 5'h08;
            OFS_STATUS:  reg_sel = 5'h09;
            default:     reg_sel = 5'h1f;
        endcase
    endfunction : reg_sel

    // Zero-wait slave, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Capture write address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wa_reg      <= 12'h000;
            wr_pend_reg <= 1'b0;
        end
        else if (hready)
        begin
            wr_pend_reg <= hsel && htrans[1] && hwrite;
            wa_reg      <= haddr[11:0];
        end
    end

    // Read mux, evaluated in the address phase and registered
    always_comb
    begin
        rd_next = 32'h0000_0000;
        unique case (reg_sel(haddr[11:0]))
            5'h00:   rd_next = ctl_reg[0];
            5'h01:   rd_next = base_reg[0];
            5'h02:   rd_next = bound_reg[0];
            5'h03:   rd_next = ofs_reg[0];
            5'h04:   rd_next = ctl_reg[1];
            5'h05:   rd_next = base_reg[1];
            5'h06:   rd_next = bound_reg[1];
            5'h07:   rd_next = ofs_reg[1];
            5'h08:   rd_next = uam_reg | UAM_FIXED;
            5'h09:   rd_next = {28'h000_0000, miss_cnt_reg, hit};
            default: rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans[1] && !hwrite)
            hrdata <= rd_next;
    end

    // Window registers; bus reset clears them like power-up
    // Reset happens synchronously for the VMEbus reset to avoid a second async net
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctl_reg[0]   <= CTL0_RESET; // [RL7] [RL8] [RL11] [RL12] [RL14] [RL15] [RL18]
            ctl_reg[1]   <= CTL1_RESET; // [RL14] [RL15]
            base_reg[0]  <= 32'h0000_0000;
            base_reg[1]  <= 32'h0000_0000;
            bound_reg[0] <= 32'h0000_0000;
            bound_reg[1] <= 32'h0000_0000;
            ofs_reg[0]   <= 32'h0000_0000;
            ofs_reg[1]   <= 32'h0000_0000;
            uam_reg      <= 32'h0000_0000; // [RL2]
        end
        else if (!vme_reset_n)
        begin
            ctl_reg[0]   <= CTL0_RESET; // [RL18]
            ctl_reg[1]   <= CTL1_RESET;
            base_reg[0]  <= 32'h0000_0000;
            base_reg[1]  <= 32'h0000_0000;
            bound_reg[0] <= 32'h0000_0000;
            bound_reg[1] <= 32'h0000_0000;
            ofs_reg[0]   <= 32'h0000_0000;
            ofs_reg[1]   <= 32'h0000_0000;
            uam_reg      <= 32'h0000_0000; // [RL2]
        end
        else if (wr_pend_reg)
        begin
            unique case (reg_sel(wa_reg))
                5'h00:   ctl_reg[0]   <= hwdata & CTL_MASK; // [RL17]
                5'h01:   base_reg[0]  <= hwdata & W0_ADDR_MASK; // [RL5]
                5'h02:   bound_reg[0] <= hwdata & W0_ADDR_MASK;
                5'h03:   ofs_reg[0]   <= hwdata & W0_ADDR_MASK;
                5'h04:   ctl_reg[1]   <= hwdata & CTL_MASK;
                5'h05:   base_reg[1]  <= hwdata & W1_ADDR_MASK; // [RL6]
                5'h06:   bound_reg[1] <= hwdata & W1_ADDR_MASK;
                5'h07:   ofs_reg[1]   <= hwdata & W1_ADDR_MASK;
                5'h08:   uam_reg      <= hwdata & UAM_MASK; // [RL1]
                default: uam_reg      <= uam_reg;
            endcase
        end
    end

    // Two windows, different granularity; window 1 has no A16
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_win
            window_match #(
                .GRAN   (i == 0 ? W0_GRAN : W1_GRAN),
                .A16_OK (i == 0)
            ) u_match (
                .ctl        (ctl_reg[i]),
                .base       (base_reg[i]),
                .bound      (bound_reg[i]),
                .offset     (ofs_reg[i]),
                .user1_am   (uam_reg[UAM1_L +: 4]),
                .user2_am   (uam_reg[UAM2_L +: 4]),
                .master_en  (bus_master_enable),
                .am         (vme_am),
                .addr       (vme_addr),
                .hit        (hit[i]),
                .local_addr (xaddr[i])
            );
        end
    endgenerate

    // Forward claimed cycle; window 0 wins if both overlap
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            local_valid    <= 1'b0;
            local_addr     <= 32'h0000_0000;
            local_space    <= LOC_MEM;
            local_write    <= 1'b0;
            local_posted   <= 1'b0;
            local_prefetch <= 1'b0;
            local_wide     <= 1'b0;
            local_lock     <= 1'b0;
            local_window   <= 1'b0;
        end
        else
        begin
            local_valid <= vme_cycle_valid && (hit != 2'b00) && vme_reset_n; // [RL3]
            if (vme_cycle_valid && (hit != 2'b00))
            begin
                local_window   <= !hit[0];
                local_addr     <= hit[0] ? xaddr[0] : xaddr[1]; // [RL16]
                local_space    <= ctl_reg[!hit[0]][CTL_LOCAL_L +: 2]; // [RL11]
                local_write    <= vme_write;
                // Decoupling only exists toward memory space
                local_posted   <= vme_write && ctl_reg[!hit[0]][CTL_POST]
                                  && (ctl_reg[!hit[0]][CTL_LOCAL_L +: 2] == LOC_MEM); // [RL12] [RL13]
                local_prefetch <= !vme_write && ctl_reg[!hit[0]][CTL_PREF]
                                  && (ctl_reg[!hit[0]][CTL_LOCAL_L +: 2] == LOC_MEM); // [RL13]
                local_wide     <= ctl_reg[!hit[0]][CTL_WIDE]; // [RL14]
                local_lock     <= vme_rmw && ctl_reg[!hit[0]][CTL_LOCK]; // [RL15]
            end
        end
    end

    // Saturating count of unclaimed cycles for software
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            miss_cnt_reg <= 2'h0;
        else if (vme_cycle_valid && (hit == 2'b00) && (miss_cnt_reg != 2'h3))
            miss_cnt_reg <= miss_cnt_reg + 2'h1;
    end
endmodule : inbound_window_decode
`default_nettype wire

// ### verification/inbound_window_checker.sv
// Port assertions for the inbound window decoder
`default_nettype none
module inbound_window_checker (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Remote cycle
    input wire logic        bus_master_enable,
    input wire logic        vme_cycle_valid,
    input wire logic [5:0]  vme_am,
    input wire logic [31:0] vme_addr,
    input wire logic        vme_write,
    input wire logic        vme_rmw,
    // Forwarded request
    input wire logic        local_valid,
    input wire logic [31:0] local_addr,
    input wire logic [1:0]  local_space,
    input wire logic        local_write,
    input wire logic        local_posted,
    input wire logic        local_prefetch,
    input wire logic        local_lock,
    input wire logic        local_window
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // A presented cycle answered one edge later
    sequence s_fwd;
        vme_cycle_valid ##1 local_valid;
    endsequence

    property p_gate;
        !bus_master_enable && vme_cycle_valid |=> !local_valid;
    endproperty
    a_gate: assert property (p_gate)
        else $error("claim while master disabled");
    property p_cause;
        local_valid |-> $past(vme_cycle_valid);
    endproperty
    a_cause: assert property (p_cause)
        else $error("request without a cycle");
    property p_low;
        s_fwd |-> local_addr[11:0] == $past(vme_addr[11:0]);
    endproperty
    a_low: assert property (p_low)
        else $error("low address bits altered");
    property p_low1;
        s_fwd ##0 local_window |-> local_addr[15:0] == $past(vme_addr[15:0]);
    endproperty
    a_low1: assert property (p_low1)
        else $error("window 1 low bits altered");
    property p_post;
        s_fwd ##0 local_posted |-> local_space == 2'h0 && local_write;
    endproperty
    a_post: assert property (p_post)
        else $error("posting outside memory writes");
    property p_pref;
        s_fwd ##0 local_prefetch |-> local_space == 2'h0 && !local_write;
    endproperty
    a_pref: assert property (p_pref)
        else $error("prefetch outside memory reads");
    property p_dir;
        s_fwd |-> local_write == $past(vme_write) && (!local_lock || $past(vme_rmw));
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction or lock mismatch");
    property p_a16;
        s_fwd ##0 local_window |-> $past(vme_am[5:3]) != 3'b101;
    endproperty
    a_a16: assert property (p_a16)
        else $error("window 1 took a short address cycle");
endmodule : inbound_window_checker

bind inbound_window_decode inbound_window_checker u_chk (.*);
`default_nettype wire

// ### verification/vme_master_model.sv
// Remote bus master model presenting one cycle per request
`default_nettype none
module vme_master_model (
    // Clock
    input wire logic        hclk,
    // Request from the bench
    input wire logic        go,
    input wire logic [5:0]  am_in,
    input wire logic [31:0] addr_in,
    input wire logic        write_in,
    input wire logic        rmw_in,
    // Remote bus lines
    output logic            vme_cycle_valid,
    output logic [5:0]      vme_am,
    output logic [31:0]     vme_addr,
    output logic            vme_write,
    output logic            vme_rmw
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle lines show the inverse, so stale values never pass for a cycle
    always_ff @(posedge hclk)
    begin
        vme_cycle_valid <= go;
        vme_am          <= go ? am_in : ~am_in;
        vme_addr        <= go ? addr_in : ~addr_in;
        vme_write       <= go ? write_in : ~write_in;
        vme_rmw         <= go ? rmw_in : ~rmw_in;
    end
endmodule : vme_master_model
`default_nettype wire

// ### verification/inbound_window_decode_tb_top.sv
// Self-checking bench for the inbound window decoder
`default_nettype none
module inbound_window_decode_tb_top;
    import inbound_window_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, go, write_in, rmw_in;
    logic        vme_reset_n, bus_master_enable, vme_cycle_valid, vme_write, vme_rmw;
    logic        local_valid, local_write, local_posted, local_prefetch;
    logic        local_wide, local_lock, local_window;
    logic [1:0]  htrans, local_space;
    logic [2:0]  hsize;
    logic [5:0]  vme_am, am_in;
    logic [31:0] haddr, hwdata, hrdata, vme_addr, addr_in, local_addr, q;
    int          errors, n_tests;
    // Register rows: offset, reset value, readback after all ones
    localparam logic [31:0] REGS [8][3] = '{
        '{32'(OFS_W0_CTL), CTL0_RESET, CTL_MASK},
        '{32'(OFS_W0_BASE), 32'h0, W0_ADDR_MASK},
        '{32'(OFS_W0_BND), 32'h0, W0_ADDR_MASK},
        '{32'(OFS_W0_OFS), 32'h0, W0_ADDR_MASK},
        '{32'(OFS_W1_CTL), CTL1_RESET, CTL_MASK},
        '{32'(OFS_W1_BASE), 32'h0, W1_ADDR_MASK},
        '{32'(OFS_USER_CODES), UAM_FIXED, UAM_MASK | UAM_FIXED},
        '{32'h0000_0f40, 32'h0, 32'h0}};
    // Window setup: offset and value
    localparam logic [31:0] PROG [9][2] = '{
        '{32'(OFS_W0_BASE), 32'h1000_0000}, '{32'(OFS_W0_BND), 32'h1000_2000},
        '{32'(OFS_W0_OFS), 32'h2000_0000}, '{32'(OFS_W0_CTL), 32'he0f2_0000},
        '{32'(OFS_W1_BASE), 32'h4000_0000}, '{32'(OFS_W1_BND), 32'h4002_0000},
        '{32'(OFS_W1_OFS), 32'h0001_0000}, '{32'(OFS_W1_CTL), 32'h80f1_00c1},
        '{32'(OFS_USER_CODES), 32'h0300_0000}};
    // Cycles: am, address, write/rmw, then valid, address, space, flags
    localparam logic [79:0] CYC [8] = '{
        {6'h0d, 32'h1000_0000, 2'b10, 1'b1, 32'h3000_0000, 7'b00_10000},
        {6'h0d, 32'h1000_2000, 2'b00, 40'h0},
        {6'h0d, 32'h0fff_fffc, 2'b00, 40'h0},
        {6'h0d, 32'h1000_1ffc, 2'b00, 1'b1, 32'h3000_1ffc, 7'b00_01000},
        {6'h3d, 32'h1000_0000, 2'b10, 40'h0},
        {6'h3d, 32'h4001_0004, 2'b01, 1'b1, 32'h4002_0004, 7'b01_00111},
        {6'h2d, 32'h4001_0004, 2'b00, 40'h0},
        {6'h3d, 32'h4001_fffc, 2'b10, 1'b1, 32'h4002_fffc, 7'b01_00101}};

    inbound_window_decode uut (.hready(hreadyout), .*);
    vme_master_model u_vme (.*);

    // Free-running bus clock
    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic print_verdict();
        $display("Checks %0d, errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Bounded wait of up to 64 edges, though this zero-wait slave never stretches a phase
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1)
        begin
            errors++;
            $display("Error at %0t: no ready", $time);
            print_verdict();
        end
    endtask : wait_ready

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask : ahb

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        check({8'h00, q}, {8'h00, e});
        check({39'h0, hresp}, 40'h0);
    endtask : rd

    task automatic vme(input logic [5:0] am, input logic [31:0] a, input logic [1:0] wr,
                       input logic [39:0] exp);
        logic [39:0] got;
        go       <= 1'b1;
        am_in    <= am;
        addr_in  <= a;
        write_in <= wr[1];
        rmw_in   <= wr[0];
        @(posedge hclk);
        go <= 1'b0;
        // Answer stands one cycle; look mid-cycle, away from its launch edge
        @(posedge hclk);
        @(negedge hclk);
        got = {local_valid, local_addr, local_space, local_posted, local_prefetch,
               local_wide, local_lock, local_window};
        check(exp[39] ? got : {got[39], 39'h0}, exp);
        if (exp[39])
            check({39'h0, local_write}, {39'h0, wr[1]});
        @(posedge hclk);
    endtask : vme

    // Main sequence
    initial
    begin
        {hresetn, hsel, hwrite, go, write_in, rmw_in, htrans} = '0;
        {haddr, hwdata, addr_in, am_in} = '0;
        hsize = 3'h2;
        vme_reset_n = 1'b1;
        bus_master_enable = 1'b1;
        errors = 0;
        n_tests = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        check({local_valid, local_addr, local_space, local_posted, local_prefetch,
               local_wide, local_lock, local_window}, 40'h0);
        check({6'h0, hrdata, hreadyout, hresp}, {6'h0, 32'h0, 2'b10});
        for (int i = 0; i < 8; i++)
        begin
            rd(REGS[i][0], REGS[i][1]);
            ahb(1'b1, REGS[i][0], 32'hffff_ffff);
            rd(REGS[i][0], REGS[i][2]);
        end
        for (int i = 0; i < 9; i++)
            ahb(1'b1, PROG[i][0], PROG[i][1]);
        for (int i = 0; i < 8; i++)
            vme(CYC[i][79:74], CYC[i][73:42], CYC[i][41:40], CYC[i][39:0]);
        // Filters narrowed to non-privileged data cycles
        ahb(1'b1, 32'(OFS_W0_CTL), 32'he052_0000);
        vme(6'h09, 32'h1000_0000, 2'b10, {1'b1, 32'h3000_0000, 7'b00_10000});
        vme(6'h0d, 32'h1000_0000, 2'b10, 40'h0);
        vme(6'h0a, 32'h1000_0000, 2'b10, 40'h0);
        // First user space with code 0x13
        ahb(1'b1, 32'(OFS_W0_CTL), 32'he0f6_0000);
        vme(6'h13, 32'h1000_0000, 2'b00, {1'b1, 32'h3000_0000, 7'b00_01000});
        bus_master_enable <= 1'b0;
        vme(6'h13, 32'h1000_0000, 2'b00, 40'h0);
        bus_master_enable <= 1'b1;
        // User codes 0x1C and 0x15 through both user spaces
        ahb(1'b1, 32'(OFS_USER_CODES), 32'h0c05_0000);
        vme(6'h1c, 32'h1000_0000, 2'b00, {1'b1, 32'h3000_0000, 7'b00_01000});
        vme(6'h13, 32'h1000_0000, 2'b00, 40'h0);
        ahb(1'b1, 32'(OFS_W0_CTL), 32'he0f7_0000);
        vme(6'h15, 32'h1000_0000, 2'b00, {1'b1, 32'h3000_0000, 7'b00_01000});
        // Short addresses decode in window 0 only
        ahb(1'b1, 32'(OFS_W0_CTL), 32'he0f0_0000);
        vme(6'h2d, 32'h1000_0000, 2'b00, {1'b1, 32'h3000_0000, 7'b00_01000});
        ahb(1'b1, 32'(OFS_W1_CTL), 32'h80f0_00c1);
        vme(6'h2d, 32'h4001_0004, 2'b00, 40'h0);
        // Posting and prefetch dropped outside memory space
        ahb(1'b1, 32'(OFS_W0_CTL), 32'he0f2_0001);
        vme(6'h0d, 32'h1000_0000, 2'b10, {1'b1, 32'h3000_0000, 7'b01_00000});
        vme(6'h0d, 32'h1000_0000, 2'b00, {1'b1, 32'h3000_0000, 7'b01_00000});
        // Bus reset restores every window field
        vme_reset_n <= 1'b0;
        @(posedge hclk);
        vme_reset_n <= 1'b1;
        rd(32'(OFS_W0_CTL), CTL0_RESET);
        rd(32'(OFS_W1_BND), 32'h0);
        vme(6'h0d, 32'h1000_0000, 2'b00, 40'h0);
        // Status: no live hit, miss count saturated
        rd(32'(OFS_STATUS), 32'h0000_000c);
        print_verdict();
    end
endmodule : inbound_window_decode_tb_top
`default_nettype wire
